// [logic/serial_prog_device.sv]
// device end of the serial program/verify port: entry, command decode, address counter
// assumes the link pins arrive asynchronously and a memory answers mem_rdata_in at once
`timescale 1ns/1ps
`default_nettype none
module serial_prog_device
    import prog_port_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    prog_link_if.device link,
    input wire logic code_protect_in,
    input wire logic [13:0] mem_rdata_in,
    output logic hold_core_reset_out,
    output logic [13:0] mem_addr_out,
    output logic [13:0] mem_wdata_out,
    output logic mem_program_out,
    output logic cfg_select_out
);
    // bit 0 clock, bit 1 data, bit 2 high voltage
    logic [2:0] sync1_r, sync1_nxt;
    logic [2:0] sync2_r, sync2_nxt;
    logic [2:0] prev_r, prev_nxt;
    dev_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [13:0] shift_r, shift_nxt;
    logic [5:0] cmd_r, cmd_nxt;
    logic [13:0] pc_r, pc_nxt;
    logic cfg_r, cfg_nxt;
    logic [13:0] word_r, word_nxt;
    logic prog_r, prog_nxt;
    logic read_r, read_nxt;
    logic oe_r, oe_nxt;
    logic do_r, do_nxt;
    logic hold_r, hold_nxt;
    logic [13:0] addr_r, addr_nxt;
    logic clk_rise, clk_fall, hv_rise, data_bit, protected_hit;
    logic [5:0] new_cmd;
    logic [13:0] pc_inc;

    always_comb begin
        sync1_nxt = {link.high_voltage_reset_pin, link.prog_data_pin, link.prog_clock_pin};
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
        clk_rise = sync2_r[0] & ~prev_r[0];
        clk_fall = ~sync2_r[0] & prev_r[0];
        hv_rise = sync2_r[2] & ~prev_r[2];
        data_bit = sync2_r[1];
        protected_hit = code_protect_in & ~cfg_r;
        new_cmd = {data_bit, cmd_r[5:1]};
        // top bit never changes on increment, so each half wraps onto itself
        pc_inc = {pc_r[HALF_BIT], pc_r[HALF_BIT-1:0] + 13'h0001};
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        pc_nxt = pc_r;
        cfg_nxt = cfg_r;
        word_nxt = word_r;
        prog_nxt = prog_r;
        read_nxt = read_r;
        oe_nxt = oe_r;
        do_nxt = do_r;
        case (state_r)
            D_OFF: begin
                oe_nxt = 1'b0;
                do_nxt = 1'b0;
                prog_nxt = 1'b0;
                if (hv_rise && !sync2_r[0] && !sync2_r[1]) begin
                    state_nxt = D_CMD;
                    pc_nxt = USER_BASE;
                    cfg_nxt = 1'b0;
                    cnt_nxt = 5'h00;
                end
            end
            D_CMD: begin
                if (clk_fall) begin
                    cmd_nxt = new_cmd;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == CMD_LAST) begin
                        cnt_nxt = 5'h00;
                        case (new_cmd)
                            CMD_LOAD_CFG: begin
                                pc_nxt = CFG_BASE;
                                cfg_nxt = 1'b1;
                                read_nxt = 1'b0;
                                state_nxt = D_DATA;
                            end
                            CMD_LOAD_DATA: begin
                                read_nxt = 1'b0;
                                state_nxt = D_DATA;
                            end
                            CMD_READ_DATA: begin
                                read_nxt = 1'b1;
                                shift_nxt = protected_hit ? 14'h0000 : mem_rdata_in;
                                state_nxt = D_DATA;
                            end
                            CMD_INC_ADDR: begin
                                pc_nxt = pc_inc;
                            end
                            CMD_BEGIN_PROG: begin
                                prog_nxt = ~protected_hit;
                            end
                            CMD_END_PROG: begin
                                prog_nxt = 1'b0;
                            end
                            default: begin
                                cmd_nxt = new_cmd;
                            end
                        endcase
                    end
                end
            end
            D_DATA: begin
                if (clk_rise && read_r) begin
                    if (cnt_r == RD_RELEASE_CNT) begin
                        oe_nxt = 1'b0;
                        do_nxt = 1'b0;
                    end else if (cnt_r >= RD_DRIVE_CNT) begin
                        oe_nxt = 1'b1;
                        do_nxt = shift_r[0];
                        shift_nxt = {1'b0, shift_r[13:1]};
                    end
                end
                if (clk_fall) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (!read_r && cnt_r >= LD_FIRST_CNT && cnt_r <= LD_LAST_CNT) begin
                        shift_nxt = {data_bit, shift_r[13:1]};
                    end
                    if (cnt_r == FRAME_LAST) begin
                        cnt_nxt = 5'h00;
                        state_nxt = D_CMD;
                        oe_nxt = 1'b0;
                        if (!read_r) begin
                            word_nxt = shift_r;
                        end
                    end
                end
            end
            default: begin
                state_nxt = D_OFF;
            end
        endcase
        // apart from rst_n_in, dropping the high voltage is the only way back to user memory
        if (!sync2_r[2] && state_r != D_OFF) begin
            state_nxt = D_OFF;
            oe_nxt = 1'b0;
            prog_nxt = 1'b0;
            cfg_nxt = 1'b0;
            pc_nxt = USER_BASE;
        end
        hold_nxt = (state_nxt != D_OFF);
        if (pc_nxt[HALF_BIT]) begin
            addr_nxt = {CFG_BASE[ADDR_BITS-1:CFG_IMPL_BITS], pc_nxt[CFG_IMPL_BITS-1:0]};
        end else begin
            addr_nxt = {{(ADDR_BITS - USER_IMPL_BITS){1'b0}}, pc_nxt[USER_IMPL_BITS-1:0]};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r <= 3'h0;
            state_r <= D_OFF;
            cnt_r <= 5'h00;
            shift_r <= 14'h0000;
            cmd_r <= 6'h00;
            pc_r <= 14'h0000;
            cfg_r <= 1'b0;
            word_r <= 14'h0000;
            prog_r <= 1'b0;
            read_r <= 1'b0;
            oe_r <= 1'b0;
            do_r <= 1'b0;
            hold_r <= 1'b0;
            addr_r <= 14'h0000;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            pc_r <= pc_nxt;
            cfg_r <= cfg_nxt;
            word_r <= word_nxt;
            prog_r <= prog_nxt;
            read_r <= read_nxt;
            oe_r <= oe_nxt;
            do_r <= do_nxt;
            hold_r <= hold_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign link.dev_data = do_r;
    assign link.dev_data_oe = oe_r;
    assign hold_core_reset_out = hold_r;
    assign mem_addr_out = addr_r;
    assign mem_wdata_out = word_r;
    assign mem_program_out = prog_r;
    assign cfg_select_out = cfg_r;
endmodule
`default_nettype wire

// [logic/serial_prog_host.sv]
// programmer end of the serial port, with a request fifo in front of it
// assumes requests arrive on the core clock; the link clock is made here by division
`timescale 1ns/1ps
`default_nettype none
module req_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0] count_r, count_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    always_comb begin
        push = in_valid_in & ready_r;
        pop = out_ready_in & (count_r != '0);
        wr_nxt = push ? ((wr_r == LAST) ? '0 : wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? ((rd_r == LAST) ? '0 : rd_r + 1'b1) : rd_r;
        count_nxt = count_r + CW'(push) - CW'(pop);
        ready_nxt = (count_nxt != FULL);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_r <= '0;
            rd_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            count_r <= count_nxt;
            ready_r <= ready_nxt;
        end
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    assign in_ready_out = ready_r;
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem_r[rd_r];
endmodule

module serial_prog_host
    import prog_port_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    prog_link_if.host link,
    input wire logic mode_on_in,
    input wire logic req_valid_in,
    input wire logic [5:0] req_cmd_in,
    input wire logic [13:0] req_word_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [13:0] rsp_word_out,
    output logic busy_out
);
    host_state_t state_r, state_nxt;
    follow_t follow_r, follow_nxt;
    logic [9:0] wait_r, wait_nxt;
    logic [4:0] cnt_r, cnt_nxt, last_r, last_nxt;
    logic high_r, high_nxt, clk_r, clk_nxt, do_r, do_nxt, oe_r, oe_nxt, hv_r, hv_nxt;
    logic [15:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic [13:0] wdata_r, wdata_nxt, rsp_r, rsp_nxt;
    logic rd_r, rd_nxt, frame_r, frame_nxt, rv_r, rv_nxt, busy_r, busy_nxt;
    logic s1_r, s2_r;
    logic f_valid, f_pop;
    logic [FIFO_WIDTH-1:0] f_data;
    logic [5:0] f_cmd;

    req_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(req_valid_in),
        .in_data_in({req_cmd_in, req_word_in}),
        .in_ready_out(req_ready_out),
        .out_valid_out(f_valid),
        .out_data_out(f_data),
        .out_ready_in(f_pop)
    );

    always_comb begin
        f_cmd = f_data[FIFO_WIDTH-1:WORD_BITS];
        f_pop = (state_r == H_IDLE) & mode_on_in;
        state_nxt = state_r;
        follow_nxt = follow_r;
        wait_nxt = wait_r + 10'h001;
        cnt_nxt = cnt_r;
        last_nxt = last_r;
        high_nxt = high_r;
        clk_nxt = clk_r;
        do_nxt = do_r;
        oe_nxt = oe_r;
        hv_nxt = hv_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        wdata_nxt = wdata_r;
        rsp_nxt = rsp_r;
        rd_nxt = rd_r;
        frame_nxt = frame_r;
        rv_nxt = 1'b0;
        case (state_r)
            H_OFF: begin
                hv_nxt = 1'b0;
                clk_nxt = 1'b0;
                do_nxt = 1'b0;
                oe_nxt = 1'b1;
                if (mode_on_in) begin
                    hv_nxt = 1'b1;
                    wait_nxt = 10'h000;
                    state_nxt = H_SETTLE;
                end
            end
            H_SETTLE: begin
                if (wait_r == GAP_LAST) begin
                    state_nxt = H_IDLE;
                end
            end
            H_IDLE: begin
                if (!mode_on_in) begin
                    hv_nxt = 1'b0;
                    state_nxt = H_OFF;
                end else if (f_valid) begin
                    tx_nxt = {10'h000, f_cmd};
                    wdata_nxt = f_data[WORD_BITS-1:0];
                    rd_nxt = (f_cmd == CMD_READ_DATA);
                    if (f_cmd == CMD_LOAD_CFG || f_cmd == CMD_LOAD_DATA || f_cmd == CMD_READ_DATA) begin
                        follow_nxt = F_DATA;
                    end else if (f_cmd == CMD_BEGIN_PROG) begin
                        follow_nxt = F_PULSE;
                    end else begin
                        follow_nxt = F_NONE;
                    end
                    last_nxt = CMD_LAST;
                    cnt_nxt = 5'h00;
                    wait_nxt = 10'h000;
                    clk_nxt = 1'b1;
                    high_nxt = 1'b1;
                    do_nxt = f_cmd[0];
                    oe_nxt = 1'b1;
                    state_nxt = H_BIT;
                end
            end
            H_BIT: begin
                if (wait_r == HALF_LAST) begin
                    wait_nxt = 10'h000;
                    if (high_r) begin
                        rx_nxt = {s2_r, rx_r[15:1]};
                        clk_nxt = 1'b0;
                        high_nxt = 1'b0;
                    end else if (cnt_r == last_r) begin
                        state_nxt = H_GAP;
                        if (frame_r && rd_r) begin
                            rsp_nxt = rx_r[14:1];
                            rv_nxt = 1'b1;
                        end
                        frame_nxt = 1'b0;
                        do_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + 5'h01;
                        clk_nxt = 1'b1;
                        high_nxt = 1'b1;
                        tx_nxt = {1'b0, tx_r[15:1]};
                        do_nxt = tx_r[1];
                    end
                end
            end
            H_GAP: begin
                if (follow_r == F_DATA && rd_r) begin
                    oe_nxt = 1'b0;
                end
                if (wait_r == GAP_LAST) begin
                    wait_nxt = 10'h000;
                    if (follow_r == F_DATA) begin
                        tx_nxt = {1'b0, wdata_r, 1'b0};
                        last_nxt = FRAME_LAST;
                        cnt_nxt = 5'h00;
                        frame_nxt = 1'b1;
                        follow_nxt = F_NONE;
                        clk_nxt = 1'b1;
                        high_nxt = 1'b1;
                        do_nxt = 1'b0;
                        state_nxt = H_BIT;
                    end else if (follow_r == F_PULSE) begin
                        state_nxt = H_PULSE;
                    end else begin
                        oe_nxt = 1'b1;
                        state_nxt = H_IDLE;
                    end
                end
            end
            H_PULSE: begin
                if (wait_r == PULSE_LAST) begin
                    tx_nxt = {10'h000, CMD_END_PROG};
                    follow_nxt = F_NONE;
                    last_nxt = CMD_LAST;
                    cnt_nxt = 5'h00;
                    wait_nxt = 10'h000;
                    clk_nxt = 1'b1;
                    high_nxt = 1'b1;
                    do_nxt = CMD_END_PROG[0];
                    state_nxt = H_BIT;
                end
            end
            default: begin
                state_nxt = H_OFF;
            end
        endcase
        busy_nxt = (state_nxt != H_IDLE);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r <= H_OFF;
            follow_r <= F_NONE;
            wait_r <= 10'h000;
            cnt_r <= 5'h00;
            last_r <= 5'h00;
            high_r <= 1'b0;
            clk_r <= 1'b0;
            do_r <= 1'b0;
            oe_r <= 1'b1;
            hv_r <= 1'b0;
            tx_r <= 16'h0000;
            rx_r <= 16'h0000;
            wdata_r <= 14'h0000;
            rsp_r <= 14'h0000;
            rd_r <= 1'b0;
            frame_r <= 1'b0;
            rv_r <= 1'b0;
            busy_r <= 1'b1;
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            follow_r <= follow_nxt;
            wait_r <= wait_nxt;
            cnt_r <= cnt_nxt;
            last_r <= last_nxt;
            high_r <= high_nxt;
            clk_r <= clk_nxt;
            do_r <= do_nxt;
            oe_r <= oe_nxt;
            hv_r <= hv_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            wdata_r <= wdata_nxt;
            rsp_r <= rsp_nxt;
            rd_r <= rd_nxt;
            frame_r <= frame_nxt;
            rv_r <= rv_nxt;
            busy_r <= busy_nxt;
            s1_r <= link.prog_data_pin;
            s2_r <= s1_r;
        end
    end

    assign link.prog_clock_pin = clk_r;
    assign link.high_voltage_reset_pin = hv_r;
    assign link.host_data = do_r;
    assign link.host_data_oe = oe_r;
    assign rsp_valid_out = rv_r;
    assign rsp_word_out = rsp_r;
    assign busy_out = busy_r;
endmodule
`default_nettype wire

// [pkg/prog_link_if.sv]
// the serial link between programmer and device: clock, data line, high voltage
// the data line is pulled low when neither end drives it
`timescale 1ns/1ps
`default_nettype none
interface prog_link_if;
    logic prog_clock_pin;
    logic high_voltage_reset_pin;
    logic host_data;
    logic host_data_oe;
    logic dev_data;
    logic dev_data_oe;
    logic prog_data_pin;

    assign prog_data_pin = host_data_oe ? host_data : (dev_data_oe ? dev_data : 1'b0);

    modport device (
        input prog_clock_pin,
        input high_voltage_reset_pin,
        input prog_data_pin,
        output dev_data,
        output dev_data_oe
    );
    modport host (
        output prog_clock_pin,
        output high_voltage_reset_pin,
        output host_data,
        output host_data_oe,
        input prog_data_pin
    );
endinterface
`default_nettype wire

// [pkg/prog_port_pkg.sv]
// constants, command codes and state types for the serial program/verify port
// assumes a single core clock of 10 MHz on both ends
package prog_port_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int GAP_TIME_NS = 1000;
    localparam int GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_TIME_US = 100;
    localparam int PULSE_CYCLES = (PULSE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int HALF_BIT_CYCLES = 8;
    localparam int WAIT_BITS = 10;
    localparam logic [9:0] GAP_LAST = 10'(GAP_CYCLES - 1);
    localparam logic [9:0] PULSE_LAST = 10'(PULSE_CYCLES - 1);
    localparam logic [9:0] HALF_LAST = 10'(HALF_BIT_CYCLES - 1);

    localparam int CMD_BITS = 6;
    localparam int FRAME_BITS = 16;
    localparam int WORD_BITS = 14;
    localparam int ADDR_BITS = 14;
    localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
    localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
    localparam logic [4:0] RD_DRIVE_CNT = 5'h01;
    localparam logic [4:0] RD_RELEASE_CNT = 5'h0f;
    localparam logic [4:0] LD_FIRST_CNT = 5'h01;
    localparam logic [4:0] LD_LAST_CNT = 5'h0e;

    localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
    localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
    localparam logic [5:0] CMD_READ_DATA = 6'h04;
    localparam logic [5:0] CMD_INC_ADDR = 6'h06;
    localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
    localparam logic [5:0] CMD_END_PROG = 6'h0e;

    localparam logic [13:0] USER_BASE = 14'h0000;
    localparam logic [13:0] CFG_BASE = 14'h2000;
    localparam int HALF_BIT = 13;
    localparam int CFG_IMPL_BITS = 8;
    localparam int USER_IMPL_BITS = 12;

    localparam int FIFO_WIDTH = CMD_BITS + WORD_BITS;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [2:0] {
        D_OFF = 3'b001,
        D_CMD = 3'b010,
        D_DATA = 3'b100
    } dev_state_t;

    typedef enum logic [5:0] {
        H_OFF = 6'b000001,
        H_SETTLE = 6'b000010,
        H_IDLE = 6'b000100,
        H_BIT = 6'b001000,
        H_GAP = 6'b010000,
        H_PULSE = 6'b100000
    } host_state_t;

    typedef enum logic [2:0] {
        F_NONE = 3'b001,
        F_DATA = 3'b010,
        F_PULSE = 3'b100
    } follow_t;
endpackage

// [testbench/prog_link_asserts.sv]
// link checker for the program/verify port
// assumes it sits beside the link interface in the core clock domain
`timescale 1ns/1ps
`default_nettype none
module prog_link_asserts (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic prog_clock_pin,
    input wire logic high_voltage_reset_pin,
    input wire logic host_data,
    input wire logic host_data_oe,
    input wire logic dev_data,
    input wire logic dev_data_oe,
    input wire logic prog_data_pin
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    entry_low_a: assert property ($rose(high_voltage_reset_pin) |->
        !prog_clock_pin && !prog_data_pin) else $error("entry with link busy");
    clock_idle_a: assert property (!high_voltage_reset_pin |-> !prog_clock_pin)
        else $error("clock moves outside mode");
    one_driver_a: assert property (!(host_data_oe && dev_data_oe))
        else $error("both ends drive data");
    high_phase_a: assert property ($rose(prog_clock_pin) |-> prog_clock_pin[*8])
        else $error("short clock high phase");
    host_hold_a: assert property ($fell(prog_clock_pin) && host_data_oe |->
        $stable(host_data)) else $error("host data moves at fall");
    dev_hold_a: assert property ($fell(prog_clock_pin) && dev_data_oe |->
        $stable(dev_data)) else $error("device data moves at fall");
    drive_rise_a: assert property ($rose(dev_data_oe) |-> prog_clock_pin)
        else $error("device drives outside high phase");
    release_rise_a: assert property ($fell(dev_data_oe) |-> prog_clock_pin)
        else $error("device releases outside high phase");
    cover property ($rose(dev_data_oe));
    cover property ($rose(high_voltage_reset_pin));
    cover property ($fell(high_voltage_reset_pin));
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// bench: programmer and device joined over the link, memory as an array
// assumes one 10 MHz core clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prog_port_pkg::*;
    logic core_clk_in = 0;
    logic rst_n_in = 0;
    logic mode_on_in = 0;
    logic code_protect_in = 0;
    logic req_valid_in = 0;
    logic [5:0] req_cmd_in = 0;
    logic [13:0] req_word_in = 0;
    logic [13:0] mem_rdata_in = 0;
    logic req_ready_out, rsp_valid_out, busy_out, hold_core_reset_out;
    logic mem_program_out, cfg_select_out;
    logic [13:0] rsp_word_out, mem_addr_out, mem_wdata_out, pc, ld;
    logic [13:0] mem [16384];
    logic [13:0] md [int];
    logic [31:0] seed = 32'h85602152;
    bit cfg;
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #50 core_clk_in = ~core_clk_in;
    prog_link_if link ();
    serial_prog_device i_serial_prog_device (.core_clk_in, .rst_n_in, .link, .code_protect_in,
        .mem_rdata_in, .hold_core_reset_out, .mem_addr_out, .mem_wdata_out, .mem_program_out,
        .cfg_select_out);
    serial_prog_host i_serial_prog_host (.core_clk_in, .rst_n_in, .link, .mode_on_in,
        .req_valid_in, .req_cmd_in, .req_word_in, .req_ready_out, .rsp_valid_out,
        .rsp_word_out, .busy_out);
    prog_link_asserts i_prog_link_asserts (.core_clk_in, .rst_n_in,
        .prog_clock_pin(link.prog_clock_pin),
        .high_voltage_reset_pin(link.high_voltage_reset_pin),
        .host_data(link.host_data), .host_data_oe(link.host_data_oe),
        .dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe),
        .prog_data_pin(link.prog_data_pin));
    // memory answers one cycle late, which is harmless since reads come long after moves
    always @(posedge core_clk_in) begin
        if (mem_program_out)
            mem[mem_addr_out] <= mem_wdata_out;
        mem_rdata_in <= mem[mem_addr_out];
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            final_report();
        end
    end
    function automatic logic [13:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[13:0];
    endfunction
    function automatic logic [13:0] pa();
        return cfg ? (14'h2000 | (pc & 14'hff)) : (pc & 14'hfff);
    endfunction
    function automatic logic [13:0] ev();
        if (!cfg && code_protect_in)
            return 14'h0;
        return md.exists(pa()) ? md[pa()] : 14'(pa() * 5);
    endfunction
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [5:0] c, input logic [13:0] w);
        @(posedge core_clk_in);
        req_valid_in <= 1;
        req_cmd_in <= c;
        req_word_in <= w;
        @(negedge core_clk_in);
        while (req_ready_out !== 1'b1)
            @(negedge core_clk_in);
        @(posedge core_clk_in);
        req_valid_in <= 0;
        case (c)
            CMD_LOAD_CFG: begin
                pc = 14'h2000;
                cfg = 1;
                ld = w;
            end
            CMD_LOAD_DATA: ld = w;
            CMD_INC_ADDR: pc = {pc[13], pc[12:0] + 13'h1};
            CMD_BEGIN_PROG: if (cfg || !code_protect_in) md[pa()] = ld;
            default: ;
        endcase
    endtask
    task automatic rd();
        logic [13:0] e;
        send(CMD_READ_DATA, 14'h0);
        // expectation taken after the push edge, so a protect change made just before counts
        e = ev();
        repeat (6000) begin
            @(negedge core_clk_in);
            if (rsp_valid_out === 1'b1)
                break;
        end
        chk(14'(rsp_valid_out), 14'h1);
        chk(rsp_word_out, e);
    endtask
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        foreach (mem[i]) mem[i] = 14'(i * 5);
        pc = 14'h0;
        ld = 14'h0;
        repeat (8) @(posedge core_clk_in);
        rst_n_in <= 1;
        mode_on_in <= 1;
        repeat (2) @(posedge core_clk_in);
        rd();
        chk(14'(hold_core_reset_out), 14'h1);
        $display("entry test done");
        send(CMD_LOAD_DATA, rnd());
        send(CMD_BEGIN_PROG, 14'h0);
        rd();
        send(CMD_INC_ADDR, 14'h0);
        send(6'h3f, rnd());
        send(6'h01, 14'h0);
        rd();
        $display("user test done");
        send(CMD_LOAD_CFG, rnd());
        send(CMD_BEGIN_PROG, 14'h0);
        rd();
        send(CMD_LOAD_DATA, rnd());
        repeat (256) send(CMD_INC_ADDR, 14'h0);
        rd();
        chk(mem_addr_out, pa());
        chk(mem_wdata_out, ld);
        chk(14'(cfg_select_out), 14'h1);
        $display("config test done");
        @(posedge core_clk_in);
        mode_on_in <= 0;
        repeat (200) @(posedge core_clk_in);
        chk(14'(hold_core_reset_out), 14'h0);
        chk(14'(cfg_select_out), 14'h0);
        code_protect_in <= 1;
        mode_on_in <= 1;
        pc = 14'h0;
        cfg = 0;
        rd();
        send(CMD_LOAD_DATA, rnd());
        send(CMD_BEGIN_PROG, 14'h0);
        send(CMD_LOAD_CFG, 14'h0);
        rd();
        // the refused pulse must leave the word programmed earlier in place
        chk(mem[14'h0], md[0]);
        repeat (20) @(negedge core_clk_in);
        chk(14'(busy_out), 14'h0);
        $display("protect test done");
        final_report();
    end
endmodule
`default_nettype wire
